// ==== src/usl_regs.vh ====
// Purpose: register map, field positions and timing counts of the LON/LIN status block
// Assumes: APB with 32-bit data, 20 MHz mclk_i
// Notes:   offsets are byte addresses, one aligned word per register
//
// Functional notes
// [R01] two idle windows kept; previous frame direction picks receive or transmit value
// [R02] transmit ends frame after last CRC bit with 3 transitionless bit periods
// [R03] receive sees end of frame after programmed transitionless length
// [R04] SPI mask view only valid when mode field is 0xE or 0xF
// [R05] SPI mask bits: 19,10,9,5,1,0; one means enabled
// [R06] LIN status view only valid when mode field is 0xA or 0xB
// [R07] header timeout 31, synch tolerance 30, responder silent 29, sticky
// [R08] checksum error in bit 28, sticky until reset-status command
// [R09] comm_type 1: late collision after CRC detected (0) or ignored (1)
// [R10] terminate bit 2 set: abort sent frame on collision in comm_type 1
// [R11] collision detection only while enable bit 1 is set
// [R12] variant bit 0: zero selects comm_type 1, one selects comm_type 2
// [R13] one write of one to reset-status clears all LIN errors; zero ignored
`ifndef USL_REGS_VH
`define USL_REGS_VH

// register offsets
`define USL_OFS_CONTROL      12'h000
`define USL_OFS_MODE         12'h004
`define USL_OFS_SPI_IEN      12'h008
`define USL_OFS_SPI_IDIS     12'h00c
`define USL_OFS_SPI_MASK     12'h010
`define USL_OFS_LIN_STATUS   12'h014
`define USL_OFS_PL_MODE      12'h018
`define USL_OFS_RX_IDLE      12'h01c
`define USL_OFS_TX_IDLE      12'h020
`define USL_OFS_IRQ_STATUS   12'h024
`define USL_OFS_IRQ_MASK     12'h028

// field positions
`define USL_CTL_RST_CMD_BIT  8
`define USL_PL_VARIANT_BIT   0
`define USL_PL_COLL_EN_BIT   1
`define USL_PL_TERM_BIT      2
`define USL_PL_CDTAIL_BIT    3
`define USL_PL_FEL_LSB       16
`define USL_PL_FEL_MSB       23
`define USL_SPI_MASK_BITS    32'h0008_0623
`define USL_LIN_HTE_BIT      31
`define USL_LIN_STE_BIT      30
`define USL_LIN_SNRE_BIT     29
`define USL_LIN_CE_BIT       28

// mode field encodings
`define USL_MODE_LIN_A       4'ha
`define USL_MODE_LIN_B       4'hb
`define USL_MODE_SPI_E       4'he
`define USL_MODE_SPI_F       4'hf

// reset values
`define USL_RST_ZERO         32'h0000_0000
`define USL_RST_FEL          8'h03
`define USL_RST_IDLE         16'h0001

// timing: bit period in ns and in mclk cycles (50 ns period)
`define USL_CLK_NS           50
`define USL_BIT_NS           1000
`define USL_BIT_CYC          ((`USL_BIT_NS + `USL_CLK_NS - 1) / `USL_CLK_NS)
`define USL_EOF_TX_BITS      2'd3

`endif

// ==== src/usl_eof_det.v ====
// Purpose: receive end-of-frame detector, counts transitionless bit periods
// Assumes: rx_line_i already synchronised, bit_en_i one-cycle pulse per bit
// Notes:   pulse on eof_o once the line stays flat for the programmed length
`timescale 1ns/1ps
module usl_eof_det (
   // clock and reset
   input  wire       mclk_i,
   input  wire       sys_rst_i,
   // timing and line
   input  wire       bit_en_i,
   input  wire       rx_line_i,
   input  wire [7:0] eof_len_i,
   // result
   output reg        eof_o,
   output reg        rx_busy_o
);

   reg        last_q;
   reg [7:0]  flat_q;

   ///////////////////////////////////////////////////////////////////
   // a transition restarts the count and marks a frame in progress
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         last_q    <= 1'b1;
         flat_q    <= 8'h00;
         eof_o     <= 1'b0;
         rx_busy_o <= 1'b0;
      end else begin
         last_q <= rx_line_i;
         eof_o  <= 1'b0;
         if (rx_line_i != last_q) begin
            flat_q    <= 8'h00;
            rx_busy_o <= 1'b1;
         end else if (bit_en_i && rx_busy_o) begin
            // zero length treated as one bit so a frame always ends
            if (flat_q + 8'h01 >= eof_len_i) begin   // [R03]
               eof_o     <= 1'b1;
               rx_busy_o <= 1'b0;
               flat_q    <= 8'h00;
            end else begin
               flat_q <= flat_q + 8'h01;
            end
         end
      end
   end

endmodule

// ==== src/usl_top.v ====
// Purpose: LON frame end, idle window and collision options; SPI mask and LIN status views
// Assumes: APB slave at 20 MHz, pins rx line and collision are asynchronous
// Notes:   answers every access with one wait state
`timescale 1ns/1ps
`include "usl_regs.vh"
module usl_top (
   // clock and reset
   input  wire        mclk_i,
   input  wire        sys_rst_i,
   // apb slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   // line pins
   input  wire        rx_line_i,
   input  wire        coll_line_i,
   output reg         tx_line_o,
   output reg         tx_line_oe_o,
   // transmit data path
   input  wire        tx_start_i,
   input  wire        tx_bit_i,
   input  wire        tx_crc_done_i,
   output reg         tx_abort_o,
   output reg         idle_wait_o,
   // lin error events and spi sources
   input  wire        lin_hdr_timeout_i,
   input  wire        lin_synch_tol_i,
   input  wire        lin_resp_silent_i,
   input  wire        lin_checksum_i,
   input  wire [31:0] spi_irq_src_i,
   // interrupt
   output reg         irq_o
);

   localparam ST_IDLE  = 3'b001;
   localparam ST_FRAME = 3'b010;
   localparam ST_EOF   = 3'b100;

   // one-hot register address decode
   function is_addr;
      input [11:0] a;
      input [11:0] ofs;
      begin
         is_addr = (a == ofs);
      end
   endfunction

   reg  [3:0]  mode_q;
   reg  [31:0] spi_mask_q;
   reg  [3:0]  lin_err_q;
   reg  [3:0]  pl_cfg_q;
   reg  [7:0]  fel_q;
   reg  [15:0] rx_idle_q;
   reg  [15:0] tx_idle_q;
   reg  [3:0]  irq_sts_q;
   reg  [3:0]  irq_msk_q;
   reg  [15:0] div_q;
   reg         bit_en_q;
   reg  [1:0]  rx_sync_q;
   reg  [1:0]  col_sync_q;
   reg  [2:0]  state_q;
   reg  [1:0]  eof_cnt_q;
   reg         post_crc_q;
   reg         last_tx_q;
   reg  [15:0] idle_cnt_q;
   reg  [31:0] rd_d;
   reg         err_d;
   wire        rx_eof;
   wire        rx_busy;
   wire        wr_acc;
   wire        rd_acc;
   wire        reset_status_cmd;
   wire        lin_view;
   wire        spi_view;
   wire        coll_seen;
   wire        tx_eof_done;
   wire [3:0]  lin_evt;
   wire [3:0]  irq_evt;

   assign wr_acc   = psel_i && penable_i && pwrite_i && !pready_o;
   assign rd_acc   = psel_i && penable_i && !pwrite_i && !pready_o;
   assign reset_status_cmd = wr_acc && is_addr(paddr_i, `USL_OFS_CONTROL)
                             && pwdata_i[`USL_CTL_RST_CMD_BIT];        // [R13]
   assign spi_view = (mode_q == `USL_MODE_SPI_E) || (mode_q == `USL_MODE_SPI_F);   // [R04]
   assign lin_view = (mode_q == `USL_MODE_LIN_A) || (mode_q == `USL_MODE_LIN_B);   // [R06]
   assign lin_evt  = {lin_hdr_timeout_i, lin_synch_tol_i, lin_resp_silent_i, lin_checksum_i};

   ///////////////////////////////////////////////////////////////////
   // bit-period enable from a divider; no second clock in this block
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         div_q    <= 16'h0000;
         bit_en_q <= 1'b0;
      end else if (div_q == `USL_BIT_CYC - 1) begin
         div_q    <= 16'h0000;
         bit_en_q <= 1'b1;
      end else begin
         div_q    <= div_q + 16'h0001;
         bit_en_q <= 1'b0;
      end
   end

   // two-flop synchronisers for the pins
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rx_sync_q  <= 2'b11;
         col_sync_q <= 2'b00;
      end else begin
         rx_sync_q  <= {rx_sync_q[0], rx_line_i};
         col_sync_q <= {col_sync_q[0], coll_line_i};
      end
   end

   ///////////////////////////////////////////////////////////////////
   // receive end of frame
   usl_eof_det u_eof (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .bit_en_i  (bit_en_q),
      .rx_line_i (rx_sync_q[1]),
      .eof_len_i (fel_q),
      .eof_o     (rx_eof),
      .rx_busy_o (rx_busy)
   );

   ///////////////////////////////////////////////////////////////////
   // collision qualification: comm_type 1 only for terminate and tail options
   assign coll_seen = col_sync_q[1] && pl_cfg_q[`USL_PL_COLL_EN_BIT]                 // [R11]
                      && !(post_crc_q && !pl_cfg_q[`USL_PL_VARIANT_BIT]
                           && pl_cfg_q[`USL_PL_CDTAIL_BIT]);                     // [R09]
   assign tx_eof_done = (state_q == ST_EOF) && bit_en_q && (eof_cnt_q == `USL_EOF_TX_BITS - 2'd1);

   // transmit frame sequencer
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_q      <= ST_IDLE;
         eof_cnt_q    <= 2'd0;
         post_crc_q   <= 1'b0;
         tx_line_o    <= 1'b1;
         tx_line_oe_o <= 1'b0;
         tx_abort_o   <= 1'b0;
      end else begin
         tx_abort_o <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               tx_line_oe_o <= 1'b0;
               post_crc_q   <= 1'b0;
               if (tx_start_i && !idle_wait_o && !rx_busy) begin
                  state_q      <= ST_FRAME;
                  tx_line_oe_o <= 1'b1;
               end
            end
            ST_FRAME: begin
               tx_line_o <= tx_bit_i;
               // terminate only applies to comm_type 1 (variant bit zero)
               if (coll_seen && !pl_cfg_q[`USL_PL_VARIANT_BIT]                       // [R12]
                   && pl_cfg_q[`USL_PL_TERM_BIT]) begin                              // [R10]
                  state_q    <= ST_IDLE;
                  tx_abort_o <= 1'b1;
               end else if (tx_crc_done_i) begin
                  state_q    <= ST_EOF;
                  eof_cnt_q  <= 2'd0;
                  post_crc_q <= 1'b1;
               end
            end
            ST_EOF: begin
               // line held as last driven: a 3-bit code violation
               // a late collision cuts the frame only in comm_type 1 with terminate set, unless told to ignore it
               if (coll_seen && !pl_cfg_q[`USL_PL_VARIANT_BIT]
                   && pl_cfg_q[`USL_PL_TERM_BIT]) begin                              // [R09] [R10]
                  state_q    <= ST_IDLE;
                  tx_abort_o <= 1'b1;
               end else if (bit_en_q) begin                                         // [R02]
                  if (tx_eof_done) begin
                     state_q      <= ST_IDLE;
                     tx_line_oe_o <= 1'b0;
                  end else begin
                     eof_cnt_q <= eof_cnt_q + 2'd1;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////
   // idle window after a frame; length depends on previous frame direction
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         last_tx_q   <= 1'b0;
         idle_cnt_q  <= 16'h0000;
         idle_wait_o <= 1'b0;
      end else if (tx_eof_done || tx_abort_o) begin
         last_tx_q   <= 1'b1;
         idle_cnt_q  <= tx_idle_q;                                                  // [R01]
         idle_wait_o <= 1'b1;
      end else if (rx_eof) begin
         last_tx_q   <= 1'b0;
         idle_cnt_q  <= rx_idle_q;                                                  // [R01]
         idle_wait_o <= 1'b1;
      end else if (idle_wait_o && bit_en_q) begin
         if (idle_cnt_q <= 16'h0001) begin
            idle_cnt_q  <= 16'h0000;
            idle_wait_o <= 1'b0;
         end else begin
            idle_cnt_q <= idle_cnt_q - 16'h0001;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////
   // sticky lin errors; a new error beats the clear in the same cycle
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         lin_err_q <= 4'h0;
      end else begin
         lin_err_q <= (reset_status_cmd ? 4'h0 : lin_err_q) | lin_evt;              // [R07] [R08]
      end
   end

   // interrupt status: tx eof, rx eof, collision, any lin error
   assign irq_evt = {|lin_evt, coll_seen && (state_q != ST_IDLE), rx_eof, tx_eof_done}; // [R09]
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         irq_sts_q <= 4'h0;
         irq_o     <= 1'b0;
      end else begin
         if (wr_acc && is_addr(paddr_i, `USL_OFS_IRQ_STATUS)) begin
            irq_sts_q <= (irq_sts_q & ~pwdata_i[3:0]) | irq_evt;
         end else begin
            irq_sts_q <= irq_sts_q | irq_evt;
         end
         irq_o <= |(irq_sts_q & irq_msk_q);
      end
   end

   ///////////////////////////////////////////////////////////////////
   // register writes
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mode_q     <= 4'h0;
         spi_mask_q <= `USL_RST_ZERO;
         pl_cfg_q   <= 4'h0;
         fel_q      <= `USL_RST_FEL;
         rx_idle_q  <= `USL_RST_IDLE;
         tx_idle_q  <= `USL_RST_IDLE;
         irq_msk_q  <= 4'h0;
      end else if (wr_acc) begin
         if (is_addr(paddr_i, `USL_OFS_MODE)) begin
            mode_q <= pwdata_i[3:0];
         end else if (is_addr(paddr_i, `USL_OFS_SPI_IEN)) begin
            spi_mask_q <= spi_mask_q | (pwdata_i & `USL_SPI_MASK_BITS);             // [R05]
         end else if (is_addr(paddr_i, `USL_OFS_SPI_IDIS)) begin
            spi_mask_q <= spi_mask_q & ~(pwdata_i & `USL_SPI_MASK_BITS);
         end else if (is_addr(paddr_i, `USL_OFS_PL_MODE)) begin
            pl_cfg_q <= pwdata_i[3:0];
            fel_q    <= pwdata_i[`USL_PL_FEL_MSB:`USL_PL_FEL_LSB];
         end else if (is_addr(paddr_i, `USL_OFS_RX_IDLE)) begin
            rx_idle_q <= pwdata_i[15:0];
         end else if (is_addr(paddr_i, `USL_OFS_TX_IDLE)) begin
            tx_idle_q <= pwdata_i[15:0];
         end else if (is_addr(paddr_i, `USL_OFS_IRQ_MASK)) begin
            irq_msk_q <= pwdata_i[3:0];
         end
      end
   end

   ///////////////////////////////////////////////////////////////////
   // read mux and unmapped detection
   always @* begin
      rd_d  = 32'h0000_0000;
      err_d = 1'b0;
      if (is_addr(paddr_i, `USL_OFS_CONTROL)) begin
         rd_d = 32'h0000_0000;
      end else if (is_addr(paddr_i, `USL_OFS_MODE)) begin
         rd_d = {28'h000_0000, mode_q};
      end else if (is_addr(paddr_i, `USL_OFS_SPI_IEN) || is_addr(paddr_i, `USL_OFS_SPI_IDIS)) begin
         rd_d = 32'h0000_0000;
      end else if (is_addr(paddr_i, `USL_OFS_SPI_MASK)) begin
         // spi view reads zero outside spi modes
         rd_d = spi_view ? spi_mask_q : 32'h0000_0000;                              // [R04] [R05]
      end else if (is_addr(paddr_i, `USL_OFS_LIN_STATUS)) begin
         rd_d = lin_view ? {lin_err_q, 28'h000_0000} : 32'h0000_0000;               // [R06]
      end else if (is_addr(paddr_i, `USL_OFS_PL_MODE)) begin
         rd_d = {8'h00, fel_q, 12'h000, pl_cfg_q};
      end else if (is_addr(paddr_i, `USL_OFS_RX_IDLE)) begin
         rd_d = {16'h0000, rx_idle_q};
      end else if (is_addr(paddr_i, `USL_OFS_TX_IDLE)) begin
         rd_d = {16'h0000, tx_idle_q};
      end else if (is_addr(paddr_i, `USL_OFS_IRQ_STATUS)) begin
         rd_d = {28'h000_0000, irq_sts_q};
      end else if (is_addr(paddr_i, `USL_OFS_IRQ_MASK)) begin
         rd_d = {28'h000_0000, irq_msk_q};
      end else begin
         err_d = 1'b1;
      end
   end

   // one wait state keeps the read mux off the bus timing path
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else if (psel_i && penable_i && !pready_o) begin
         pready_o  <= 1'b1;
         pslverr_o <= err_d;
         prdata_o  <= rd_acc ? rd_d : 32'h0000_0000;
      end else begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

endmodule

// ==== tb/usl_checker.sv ====
// Purpose: port assertions for usl_top
// Assumes: one clock, sync reset active high
// Notes:   sees top ports only, bound below
`timescale 1ns/1ps
module usl_chk (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // frame side
   input wire logic tx_line_o,
   input wire logic tx_line_oe_o,
   input wire logic tx_start_i,
   input wire logic tx_crc_done_i,
   input wire logic tx_abort_o,
   input wire logic idle_wait_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////////////////////////
   // apb answer: one wait state, one-cycle ready, error only with ready
   rdy_answer_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("access not answered");
   rdy_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   rdy_cause_a: assert property (pready_o |-> $past(psel_i) && $past(penable_i))
      else $error("ready without access");
   err_ready_a: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   // frame end: abort legally cuts it short, so it cancels the check
   eof_flat_a: assert property (disable iff (sys_rst_i || tx_abort_o)
      tx_crc_done_i && tx_line_oe_o |=> $stable(tx_line_o) [*8])
      else $error("line moved after last crc bit");
   eof_len_a: assert property (disable iff (sys_rst_i || tx_abort_o)
      tx_crc_done_i && tx_line_oe_o |-> ##[40:62] $fell(tx_line_oe_o))
      else $error("frame end not three bit periods");
   idle_follow_a: assert property ($fell(tx_line_oe_o) |-> ##[0:1] idle_wait_o)
      else $error("no idle window after frame");
   start_block_a: assert property (tx_start_i && idle_wait_o |=> !$rose(tx_line_oe_o))
      else $error("start taken in idle window");
   abort_drop_a: assert property (tx_abort_o |-> ##[0:2] !tx_line_oe_o)
      else $error("abort left driver on");
   // main scenarios reached
   cover property (tx_abort_o);
   cover property ($fell(tx_line_oe_o) && !tx_abort_o);
   cover property (pslverr_o);
endmodule

bind usl_top usl_chk u_chk (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_line_o(tx_line_o),
   .tx_line_oe_o(tx_line_oe_o), .tx_start_i(tx_start_i), .tx_crc_done_i(tx_crc_done_i),
   .tx_abort_o(tx_abort_o), .idle_wait_o(idle_wait_o)
);

// ==== tb/usl_node_model.sv ====
// Purpose: another node on the line, sends one frame or reports a collision
// Assumes: HALF cycles per half bit, larger values give a slow node
// Notes:   line stays flat after the frame, that flatness is the frame end
`timescale 1ns/1ps
module usl_node_model #(parameter int HALF = 10) (
   // clock
   input wire logic mclk_i,
   // commands
   input wire logic go_i,
   input wire logic coll_i,
   // line side
   output logic     rx_line_o,
   output logic     coll_line_o,
   output logic     done_o
);
   int cnt = 0, n = 0, hold = 0;
   initial begin
      rx_line_o = 1'b1;
      coll_line_o = 1'b0;
      done_o = 1'b0;
   end
   // a transition every half bit, then no transition at all
   always @(posedge mclk_i) begin
      done_o <= 1'b0;
      if (go_i && n == 0) begin
         n <= 16;
         cnt <= HALF;
      end else if (n != 0 && cnt == 1) begin
         rx_line_o <= ~rx_line_o;
         n <= n - 1;
         cnt <= HALF;
         done_o <= (n == 1);
      end else if (n != 0) cnt <= cnt - 1;
      // report held a bit period so a synchroniser cannot miss it
      hold <= coll_i ? 2 * HALF : (hold != 0 ? hold - 1 : 0);
      coll_line_o <= coll_i || hold > 1;
   end
endmodule

// ==== tb/usart_lon_lin_status_test.sv ====
// Purpose: self-checking bench for usl_top
// Assumes: 20 MHz clock, 20 cycles per bit period
// Notes:   register table first, then lin, interrupt, receive and collision cases
`timescale 1ns/1ps
module usart_lon_lin_status_test;
   typedef struct packed {logic w; logic [11:0] a; logic [31:0] d, x; logic e;} usl_row_t;
   usl_row_t    rows [16];
   logic        mclk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [11:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, rd, exp;
   logic        pready_o, pslverr_o, er, tx_line_o, tx_line_oe_o, tx_abort_o, idle_wait_o;
   logic        tx_start_i = 0, tx_bit_i = 0, tx_crc_done_i = 0, irq_o, seen;
   logic        rx_line_i, coll_line_i, go = 0, coll = 0, rx_done;
   logic [3:0]  lin_err = 0, cm [6];
   logic [5:0]  late = 6'b110000, ab = 6'b010001;
   int          bad_count = 0, n_checks = 0, n;
   usl_top u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .rx_line_i(rx_line_i), .coll_line_i(coll_line_i), .tx_line_o(tx_line_o),
      .tx_line_oe_o(tx_line_oe_o), .tx_start_i(tx_start_i), .tx_bit_i(tx_bit_i),
      .tx_crc_done_i(tx_crc_done_i), .tx_abort_o(tx_abort_o), .idle_wait_o(idle_wait_o),
      .lin_hdr_timeout_i(lin_err[3]), .lin_synch_tol_i(lin_err[2]),
      .lin_resp_silent_i(lin_err[1]), .lin_checksum_i(lin_err[0]),
      .spi_irq_src_i(32'h0000_0000), .irq_o(irq_o));
   usl_node_model u_node (.mclk_i(mclk_i), .go_i(go), .coll_i(coll),
      .rx_line_o(rx_line_i), .coll_line_o(coll_line_i), .done_o(rx_done));
   // 50 ns clock
   always #25 mclk_i = ~mclk_i;
   ////////////////////////////////////////////////////////////
   task automatic fail(input string m);
      bad_count++;
      $display("BAD %0t %s", $time, m);
   endtask
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) fail(m);
   endtask
   task automatic report_and_stop;
      if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // apb master: setup, access held until ready, data taken at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk_i);
      psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1;
      k = 0;
      do begin @(posedge mclk_i); k++; end while (pready_o !== 1'b1 && k < 20);
      if (k >= 20) begin fail("apb hang"); report_and_stop; end
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   // bounded wait on driver enable, idle window or partner frame end
   task automatic wait_for(input int s, input logic v, input int lim);
      n = 0;
      while ((s == 0 ? tx_line_oe_o : s == 1 ? idle_wait_o : rx_done) !== v) begin
         @(posedge mclk_i);
         n++;
         if (n > lim) begin fail("wait hang"); report_and_stop; end
      end
   endtask
   task automatic pulse_start;
      tx_start_i <= 1; @(posedge mclk_i); tx_start_i <= 0;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      rows = '{'{0,12'h010,0,0,0}, '{0,12'h014,0,0,0}, '{0,12'h018,0,32'h0003_0000,0},
         '{0,12'h01c,0,1,0}, '{0,12'h020,0,1,0}, '{1,12'h008,32'hffff_ffff,0,0},
         '{0,12'h010,0,0,0}, '{1,12'h004,32'he,0,0}, '{0,12'h010,0,32'h0008_0623,0},
         '{1,12'h00c,1,0,0}, '{1,12'h004,32'hf,0,0}, '{0,12'h010,0,32'h0008_0622,0},
         '{1,12'h010,32'hffff_ffff,0,0}, '{1,12'h004,32'ha,0,0}, '{0,12'h010,0,0,0},
         '{0,12'h0fc,0,0,1}};
      cm = '{4'h6, 4'h7, 4'h4, 4'h2, 4'h6, 4'he};
      repeat (6) @(posedge mclk_i);
      chk(pready_o === 0 && tx_line_oe_o === 0 && irq_o === 0 && tx_line_o === 1, "reset outputs");
      sys_rst_i <= 0;
      // register table and view selection
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(rd === rows[i].x, "read data");
         chk(er === rows[i].e, "error flag");
      end
      // lin flags, one event at a time, each stays set
      exp = 0;
      for (int b = 3; b >= 0; b--) begin
         lin_err <= 4'h1 << b; @(posedge mclk_i); lin_err <= 4'h0;
         exp[28+b] = 1'b1;
         apb(0, 12'h014, 0);
         chk(rd === exp, "lin flag");
      end
      apb(1, 12'h004, 32'hb);
      apb(0, 12'h014, 0);
      chk(rd === exp, "lin view b");
      apb(1, 12'h000, 32'h0000_00ff);
      apb(0, 12'h014, 0);
      chk(rd === exp, "zero cleared flags");
      apb(1, 12'h000, 32'h0000_0100);
      apb(0, 12'h014, 0);
      chk(rd === 0, "flags not cleared");
      // interrupt: masked, enabled, cleared
      apb(0, 12'h024, 0);
      chk(rd[3] === 1'b1 && irq_o === 1'b0, "masked irq");
      apb(1, 12'h028, 32'h8);
      repeat (2) @(posedge mclk_i);
      chk(irq_o === 1'b1, "irq low");
      apb(1, 12'h024, 32'h8);
      repeat (2) @(posedge mclk_i);
      chk(irq_o === 1'b0, "irq not cleared");
      // received frame: end after five flat bits, then receive-side window
      apb(1, 12'h018, 32'h0005_0000);
      apb(1, 12'h01c, 32'h6);
      apb(1, 12'h020, 32'h3);
      go <= 1; @(posedge mclk_i); go <= 0;
      wait_for(2, 1, 400);
      wait_for(1, 1, 200);
      chk(n >= 80 && n <= 106, "rx frame end");
      wait_for(1, 0, 300);
      chk(n >= 100 && n <= 122, "rx window");
      apb(0, 12'h024, 0);
      chk(rd[1] === 1'b1, "rx end status");
      // sent frames with collisions in each option setting
      foreach (cm[i]) begin
         apb(1, 12'h018, {28'h0003_000, cm[i]});
         wait_for(1, 0, 300);
         pulse_start;
         wait_for(0, 1, 5);
         repeat (3) begin tx_bit_i <= ~tx_bit_i; repeat (20) @(posedge mclk_i); end
         chk(tx_line_o === tx_bit_i, "line level");
         if (late[i]) begin tx_crc_done_i <= 1; @(posedge mclk_i); tx_crc_done_i <= 0; end
         if (late[i]) apb(1, 12'h024, 32'h4);
         coll <= 1; @(posedge mclk_i); coll <= 0;
         seen = 0;
         repeat (40) begin @(posedge mclk_i); if (tx_abort_o === 1'b1) seen = 1; end
         chk(seen === ab[i], "abort");
         if (late[i]) begin apb(0, 12'h024, 0); chk(rd[2] === ~cm[i][3], "late coll"); end
         if (!late[i]) chk(tx_line_oe_o === !ab[i], "frame state");
         if (!late[i] && !ab[i]) begin
            tx_crc_done_i <= 1; @(posedge mclk_i); tx_crc_done_i <= 0;
            tx_bit_i <= ~tx_bit_i;
            wait_for(0, 0, 80);
            chk(n >= 39 && n <= 63, "frame end length");
            chk(tx_line_o === ~tx_bit_i, "line moved in frame end");
            @(posedge mclk_i);
            pulse_start;
            wait_for(1, 0, 100);
            chk(n >= 36 && n <= 62, "tx window");
         end
         wait_for(0, 0, 100);
      end
      report_and_stop;
   end
endmodule
